// >>> bench/flash_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model #(
	parameter int BUSY_READS = 4,
	// Identification codes are arbitrary values.
	parameter logic [15:0] MAKER_CODE = 16'h00A1,
	parameter logic [15:0] PART_CODE = 16'h00B2
) (
	input wire flash_host_pkg::pins_t i_pins,
	input wire logic i_hang,
	output logic [15:0] o_dq,
	output logic o_fault
);
	logic [5:0][19:0] hist;
	logic [63:0] erased;
	logic id_mode;
	logic tog;
	logic poll_set;
	logic [20:0] poll_addr;
	int busy;
	realtime t_rel;
	wire rd_n = i_pins.ce_n | i_pins.oe_n | ~i_pins.we_n;
	initial
	begin
		o_dq = 16'h0000;
		o_fault = 1'b0;
		id_mode = 1'b0;
		tog = 1'b0;
		busy = 0;
		erased = '0;
		hist = '0;
		poll_set = 1'b0;
		t_rel = -1000.0;
	end
	always @(negedge i_pins.we_n)
	begin
		if (!i_pins.ce_n)
		begin
			if (!i_pins.oe_n)
				o_fault = 1'b1;
			hist = {hist[4:0], i_pins.addr[11:0], i_pins.dq_out[7:0]};
			if (hist[5:1] == {20'h555AA, 20'h2AA55, 20'h55580, 20'h555AA, 20'h2AA55}
				&& (hist[0] == 20'h55510 || hist[0][7:0] == 8'h30))
			begin
				if (hist[0][7:0] == 8'h10)
					erased = '1;
				else
					erased[i_pins.addr[20:15]] = 1'b1;
				busy = BUSY_READS;
				poll_set = 1'b0;
				hist = '0;
			end
			else if (hist[2:0] == {20'h555AA, 20'h2AA55, 20'h55590})
				id_mode = 1'b1;
			else if (id_mode && hist[0][7:0] == 8'hF0)
				id_mode = 1'b0;
		end
	end
	always @(negedge rd_n)
	begin
		if ($realtime - t_rel < 50.0)
			o_fault = 1'b1;
		if (busy > 0)
		begin
			if (poll_set && i_pins.addr != poll_addr)
				o_fault = 1'b1;
			poll_set = 1'b1;
			poll_addr = i_pins.addr;
			tog = ~tog;
			if (!i_hang)
				busy--;
			o_dq = 16'h0000;
			o_dq[flash_host_pkg::TOGGLE_STATUS_LINE] = tog;
		end
		else if (id_mode && i_pins.addr[20:1] == 20'h00000)
			o_dq = i_pins.addr[0] ? PART_CODE : MAKER_CODE;
		else
			o_dq = erased[i_pins.addr[20:15]] ? 16'hFFFF : (i_pins.addr[15:0] ^ 16'h5A3C);
	end
	// A released bus shows the inverse so a stale value never passes.
	always @(posedge rd_n)
	begin
		t_rel = $realtime;
		o_dq = ~o_dq;
	end
endmodule
`default_nettype wire

// >>> bench/flash_host_tb.sv
`timescale 1ns/10ps
`default_nettype none
module flash_host_tb;
	localparam logic [15:0] MAKER = 16'h00A1;
	localparam logic [15:0] PART = 16'h00B2;
	logic i_ref_clk, i_rstn, i_cmd_valid, hang, fault;
	logic o_cmd_ready, o_done, o_timeout, o_id_mode;
	logic [15:0] o_rdata, dq;
	flash_host_pkg::cmd_t i_cmd;
	flash_host_pkg::pins_t o_flash;
	int bad_count, checked;
	flash_host #(.CHIP_TIMEOUT_CYC(32'hC8), .SECTOR_TIMEOUT_CYC(32'h64)) flash_host_inst (
		.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
		.o_cmd_ready(o_cmd_ready), .o_done(o_done), .o_timeout(o_timeout),
		.o_id_mode(o_id_mode), .o_rdata(o_rdata), .o_flash(o_flash), .i_flash_dq(dq));
	flash_dev_model #(.BUSY_READS(4), .MAKER_CODE(MAKER), .PART_CODE(PART))
		flash_dev_model_inst (.i_pins(o_flash), .i_hang(hang), .o_dq(dq), .o_fault(fault));
	initial
	begin
		i_ref_clk = 1'b0;
		forever #50 i_ref_clk = ~i_ref_clk;
	end
	function automatic logic [15:0] pat(input logic [20:0] a);
		return a[15:0] ^ 16'h5A3C;
	endfunction
	task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk1(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic run(input flash_host_pkg::op_t op, input logic [20:0] a);
		int n;
		n = 0;
		@(negedge i_ref_clk);
		while (o_cmd_ready !== 1'b1 && n < 50)
		begin
			@(negedge i_ref_clk);
			n++;
		end
		i_cmd_valid = 1'b1;
		i_cmd.op = op;
		i_cmd.addr = a;
		@(negedge i_ref_clk);
		i_cmd_valid = 1'b0;
		n = 0;
		while (o_done !== 1'b1 && n < 400)
		begin
			@(negedge i_ref_clk);
			n++;
		end
		chk1("done", 1'b1, o_done);
	endtask
	task automatic read_chk(input logic [20:0] a, input logic [15:0] exp, input string what);
		run(flash_host_pkg::OP_READ, a);
		chk16(what, exp, o_rdata);
	endtask
	task automatic t_reset_and_array();
		chk1("ready", 1'b1, o_cmd_ready);
		chk1("ce_n", 1'b1, o_flash.ce_n);
		chk1("id_mode", 1'b0, o_id_mode);
		read_chk(21'h012345, pat(21'h012345), "array word");
	endtask
	task automatic t_sector();
		run(flash_host_pkg::OP_SECTOR_ERASE, 21'h018000);
		chk1("timeout", 1'b0, o_timeout);
		read_chk(21'h01ABCD, 16'hFFFF, "erased word");
		read_chk(21'h020004, pat(21'h020004), "kept word");
	endtask
	task automatic t_ident(input flash_host_pkg::op_t ex);
		run(flash_host_pkg::OP_ID_ENTRY, 21'h000000);
		chk1("id_mode", 1'b1, o_id_mode);
		read_chk(21'h000000, MAKER, "maker code");
		read_chk(21'h000001, PART, "part code");
		run(ex, 21'h000000);
		chk1("id_mode", 1'b0, o_id_mode);
		read_chk(21'h000000, pat(21'h000000), "array after exit");
	endtask
	task automatic t_chip();
		run(flash_host_pkg::OP_CHIP_ERASE, 21'h000000);
		chk1("timeout", 1'b0, o_timeout);
		read_chk(21'h1F0F0F, 16'hFFFF, "chip erased");
		chk1("pin fault", 1'b0, fault);
	endtask
	task automatic t_hang();
		@(negedge i_ref_clk);
		hang = 1'b1;
		// A status that never settles must end in the timeout flag.
		run(flash_host_pkg::OP_SECTOR_ERASE, 21'h100000);
		chk1("timeout", 1'b1, o_timeout);
		chk16("status other bits", 16'h0000, o_rdata & 16'hFFBF);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#2000000;
		bad_count++;
		report_and_stop();
	end
	initial
	begin
		bad_count = 0;
		checked = 0;
		i_rstn = 1'b0;
		i_cmd_valid = 1'b0;
		i_cmd = '0;
		hang = 1'b0;
		repeat (5) @(negedge i_ref_clk);
		i_rstn = 1'b1;
		t_reset_and_array();
		t_sector();
		t_ident(flash_host_pkg::OP_ID_EXIT_SHORT);
		t_ident(flash_host_pkg::OP_ID_EXIT_LONG);
		t_chip();
		t_hang();
		report_and_stop();
	end
endmodule
`default_nettype wire

// >>> rtl/flash_host.sv
`timescale 1ns/10ps
`default_nettype none
module flash_host #(
	parameter logic [31:0] CHIP_TIMEOUT_CYC =
		32'(longint'(flash_host_pkg::CHIP_ERASE_MAX_S * real'(flash_host_pkg::CLK_HZ))),
	parameter logic [31:0] SECTOR_TIMEOUT_CYC =
		32'(longint'(flash_host_pkg::SECTOR_ERASE_MAX_S * real'(flash_host_pkg::CLK_HZ)))
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_cmd_valid,
	input wire flash_host_pkg::cmd_t i_cmd,
	output logic o_cmd_ready,
	output logic o_done,
	output logic o_timeout,
	output logic o_id_mode,
	output logic [flash_host_pkg::DATA_W-1:0] o_rdata,
	output flash_host_pkg::pins_t o_flash,
	input wire logic [flash_host_pkg::DATA_W-1:0] i_flash_dq
);

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WSET = 3'h1,
		ST_WLOW = 3'h2,
		ST_WHIGH = 3'h3,
		ST_RLOW = 3'h4,
		ST_RHIGH = 3'h5,
		ST_DECIDE = 3'h6,
		ST_DONE = 3'h7
	} state_t;

	state_t state_reg, state_next;
	flash_host_pkg::op_t op_reg, op_next;
	logic [flash_host_pkg::ADDR_W-1:0] addr_reg, addr_next;
	logic [2:0] step_reg, step_next;
	logic [3:0] wait_reg, wait_next;
	logic [31:0] tmo_reg, tmo_next;
	logic prev_reg, prev_next;
	logic have_prev_reg, have_prev_next;
	logic polling_reg, polling_next;
	logic err_reg, err_next;
	logic id_mode_reg, id_mode_next;
	logic done_reg, done_next;
	logic [flash_host_pkg::DATA_W-1:0] rdata_reg, rdata_next;
	flash_host_pkg::pins_t pins_reg, pins_next;
	logic [flash_host_pkg::DATA_W-1:0] dq_s1_reg, dq_s2_reg, dq_s3_reg, dq_acc_reg;
	flash_host_pkg::cmd_word_t word;

	// Command table: address, low data byte and last-step flag per step.
	function automatic flash_host_pkg::cmd_word_t cmd_word(input flash_host_pkg::op_t op,
		input logic [2:0] step);
		flash_host_pkg::cmd_word_t w;
		w.addr = flash_host_pkg::UNLOCK_ADDR_1;
		w.data = flash_host_pkg::UNLOCK_DATA_1;
		w.last = 1'b0;
		if (step == 3'h1 || step == 3'h4)
		begin
			w.addr = flash_host_pkg::UNLOCK_ADDR_2;
			w.data = flash_host_pkg::UNLOCK_DATA_2;
		end
		unique case (op)
			flash_host_pkg::OP_CHIP_ERASE, flash_host_pkg::OP_SECTOR_ERASE:
			begin
				if (step == 3'h2)
					w.data = flash_host_pkg::ERASE_SETUP_DATA;
				w.last = (step == flash_host_pkg::ERASE_STEPS - 3'h1);
				if (w.last && op == flash_host_pkg::OP_CHIP_ERASE)
					w.data = flash_host_pkg::CHIP_ERASE_DATA;
				if (w.last && op == flash_host_pkg::OP_SECTOR_ERASE)
					w.data = flash_host_pkg::SECTOR_ERASE_DATA;
			end
			flash_host_pkg::OP_ID_ENTRY, flash_host_pkg::OP_ID_EXIT_LONG:
			begin
				w.last = (step == flash_host_pkg::ID_LONG_STEPS - 3'h1);
				if (w.last)
					w.data = (op == flash_host_pkg::OP_ID_ENTRY) ?
						flash_host_pkg::ID_ENTRY_DATA : flash_host_pkg::ID_EXIT_DATA;
			end
			flash_host_pkg::OP_ID_EXIT_SHORT, flash_host_pkg::OP_READ:
			begin
				w.data = flash_host_pkg::ID_EXIT_DATA;
				w.last = 1'b1;
			end
		endcase
		return w;
	endfunction

	function automatic logic is_erase(input flash_host_pkg::op_t op);
		return op == flash_host_pkg::OP_CHIP_ERASE || op == flash_host_pkg::OP_SECTOR_ERASE;
	endfunction

	always_comb
	begin
		state_next = state_reg;
		op_next = op_reg;
		addr_next = addr_reg;
		step_next = step_reg;
		wait_next = (state_next == state_reg) ? wait_reg + 4'h1 : 4'h0;
		tmo_next = tmo_reg;
		prev_next = prev_reg;
		have_prev_next = have_prev_reg;
		polling_next = polling_reg;
		err_next = err_reg;
		id_mode_next = id_mode_reg;
		done_next = 1'b0;
		rdata_next = rdata_reg;
		word = cmd_word(op_reg, step_reg);
		if (polling_reg && tmo_reg != 32'h0)
			tmo_next = tmo_reg - 32'h1;
		unique case (state_reg)
			ST_IDLE:
			begin
				if (i_cmd_valid)
				begin
					op_next = i_cmd.op;
					addr_next = i_cmd.addr;
					step_next = 3'h0;
					err_next = 1'b0;
					state_next = (i_cmd.op == flash_host_pkg::OP_READ) ? ST_RLOW : ST_WSET;
				end
			end
			ST_WSET:
				state_next = ST_WLOW;
			ST_WLOW:
				if (wait_reg == 4'(flash_host_pkg::WRITE_PULSE_CYC - 1))
					state_next = ST_WHIGH;
			ST_WHIGH:
			begin
				if (wait_reg == 4'(flash_host_pkg::WRITE_HIGH_CYC - 1))
				begin
					step_next = step_reg + 3'h1;
					state_next = ST_WSET;
					if (word.last)
					begin
						state_next = is_erase(op_reg) ? ST_RLOW : ST_DONE;
						polling_next = is_erase(op_reg);
						have_prev_next = 1'b0;
						tmo_next = SECTOR_TIMEOUT_CYC;
						if (op_reg == flash_host_pkg::OP_CHIP_ERASE)
							tmo_next = CHIP_TIMEOUT_CYC;
						if (op_reg == flash_host_pkg::OP_ID_ENTRY)
							id_mode_next = 1'b1;
						if (op_reg == flash_host_pkg::OP_ID_EXIT_LONG ||
							op_reg == flash_host_pkg::OP_ID_EXIT_SHORT)
							id_mode_next = 1'b0;
					end
				end
			end
			ST_RLOW:
			begin
				// Data takes three stages to settle, so the low phase runs one cycle past them.
				if (wait_reg == 4'(flash_host_pkg::READ_LOW_CYC))
				begin
					rdata_next = dq_acc_reg;
					state_next = ST_RHIGH;
				end
			end
			ST_RHIGH:
				if (wait_reg == 4'(flash_host_pkg::STROBE_HIGH_CYC))
					state_next = polling_reg ? ST_DECIDE : ST_DONE;
			ST_DECIDE:
			begin
				if (have_prev_reg && prev_reg == rdata_reg[flash_host_pkg::TOGGLE_STATUS_LINE])
					state_next = ST_DONE;
				else if (tmo_reg == 32'h0)
				begin
					err_next = 1'b1;
					state_next = ST_DONE;
				end
				else
				begin
					have_prev_next = 1'b1;
					prev_next = rdata_reg[flash_host_pkg::TOGGLE_STATUS_LINE];
					state_next = ST_RLOW;
				end
			end
			ST_DONE:
			begin
				polling_next = 1'b0;
				done_next = 1'b1;
				state_next = ST_IDLE;
			end
		endcase
		wait_next = (state_next == state_reg) ? wait_reg + 4'h1 : 4'h0;
	end

	// Pins are registered from the next state so the device sees no decode glitches.
	always_comb
	begin
		flash_host_pkg::cmd_word_t w;
		w = cmd_word(op_next, step_next);
		pins_next.ce_n = 1'b1;
		pins_next.oe_n = 1'b1;
		pins_next.we_n = 1'b1;
		pins_next.addr = addr_next;
		pins_next.dq_out = pins_reg.dq_out;
		pins_next.dq_oe = 1'b0;
		unique case (state_next)
			ST_WSET, ST_WLOW, ST_WHIGH:
			begin
				// low byte only; low address except on the sector erase final word, which drives the full address
				pins_next.addr = {9'h000, w.addr};
				if (w.last && op_next == flash_host_pkg::OP_SECTOR_ERASE)
					pins_next.addr = addr_next;
				pins_next.dq_out = {8'h00, w.data};
				pins_next.dq_oe = 1'b1;
				pins_next.ce_n = (state_next == ST_WHIGH);
				pins_next.we_n = (state_next != ST_WLOW);
			end
			ST_RLOW:
			begin
				pins_next.ce_n = 1'b0;
				pins_next.oe_n = 1'b0;
			end
			ST_IDLE, ST_RHIGH, ST_DECIDE, ST_DONE:
			begin
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state_reg <= ST_IDLE;
			op_reg <= flash_host_pkg::OP_READ;
			addr_reg <= '0;
			step_reg <= 3'h0;
			wait_reg <= 4'h0;
			tmo_reg <= 32'h0;
			prev_reg <= 1'b0;
			have_prev_reg <= 1'b0;
			polling_reg <= 1'b0;
			err_reg <= 1'b0;
			id_mode_reg <= 1'b0;
			done_reg <= 1'b0;
			rdata_reg <= '0;
			pins_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
			dq_s1_reg <= '0;
			dq_s2_reg <= '0;
			dq_s3_reg <= '0;
			dq_acc_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			op_reg <= op_next;
			addr_reg <= addr_next;
			step_reg <= step_next;
			wait_reg <= wait_next;
			tmo_reg <= tmo_next;
			prev_reg <= prev_next;
			have_prev_reg <= have_prev_next;
			polling_reg <= polling_next;
			err_reg <= err_next;
			id_mode_reg <= id_mode_next;
			done_reg <= done_next;
			rdata_reg <= rdata_next;
			pins_reg <= pins_next;
			dq_s1_reg <= i_flash_dq;
			dq_s2_reg <= dq_s1_reg;
			dq_s3_reg <= dq_s2_reg;
			if (dq_s2_reg == dq_s3_reg)
				dq_acc_reg <= dq_s3_reg;
		end
	end

	assign o_cmd_ready = (state_reg == ST_IDLE);
	assign o_done = done_reg;
	assign o_timeout = err_reg;
	assign o_id_mode = id_mode_reg;
	assign o_rdata = rdata_reg;
	assign o_flash = pins_reg;

	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);

	chk_oe_during_write: assert property (!o_flash.we_n |-> o_flash.oe_n && !o_flash.ce_n)
		else $error("output enable low during a write strobe");
	chk_chip_final_word: assert property (state_reg == ST_WLOW
		&& op_reg == flash_host_pkg::OP_CHIP_ERASE && word.last
		|-> o_flash.dq_out == {8'h00, flash_host_pkg::CHIP_ERASE_DATA}
		&& o_flash.addr == {9'h000, flash_host_pkg::UNLOCK_ADDR_1})
		else $error("chip erase final word wrong");
	chk_sector_final_word: assert property (state_reg == ST_WLOW
		&& op_reg == flash_host_pkg::OP_SECTOR_ERASE && word.last
		|-> o_flash.dq_out == {8'h00, flash_host_pkg::SECTOR_ERASE_DATA}
		&& o_flash.addr == addr_reg)
		else $error("sector erase final word wrong");
	chk_strobe_high_gap: assert property ($fell(o_flash.oe_n) && polling_reg
		|-> $past(o_flash.oe_n, 1) && $past(o_flash.oe_n, 2))
		else $error("status strobe high too short");
	chk_poll_addr_fixed: assert property (polling_reg && !o_flash.oe_n
		|-> o_flash.addr == addr_reg && $stable(addr_reg))
		else $error("polling address moved");
	chk_cmd_upper_zero: assert property (o_flash.dq_oe |-> o_flash.dq_out[15:8] == 8'h00)
		else $error("upper data byte driven nonzero");
	chk_toggle_stop_done: assert property (state_reg == ST_DECIDE && have_prev_reg
		&& prev_reg == rdata_reg[flash_host_pkg::TOGGLE_STATUS_LINE]
		|=> state_reg == ST_DONE ##1 o_done && !o_timeout)
		else $error("stable status bit did not finish");
	chk_timeout_flag: assert property (state_reg == ST_DECIDE && tmo_reg == 32'h0
		&& !(have_prev_reg && prev_reg == rdata_reg[flash_host_pkg::TOGGLE_STATUS_LINE])
		|=> ##1 o_done && o_timeout)
		else $error("erase timeout not reported");
	chk_exit_clears_id: assert property (state_reg == ST_WHIGH && word.last
		&& (op_reg == flash_host_pkg::OP_ID_EXIT_LONG
		|| op_reg == flash_host_pkg::OP_ID_EXIT_SHORT) && wait_reg == 4'h0
		|=> !o_id_mode)
		else $error("identification mode not left");

endmodule
`default_nettype wire

// >>> rtl/flash_host_pkg.sv
package flash_host_pkg;

	localparam longint CLK_HZ = 10_000_000;
	localparam int CLK_PERIOD_NS = 100;

	// Pin timing minimums and the read access maximum, in nanoseconds, and the cycle counts that meet them.
	localparam int WRITE_PULSE_MIN_NS = 35;
	localparam int WRITE_HIGH_MIN_NS = 35;
	localparam int READ_ACCESS_MAX_NS = 70;
	localparam int STROBE_HIGH_MIN_TIME_NS = 50;
	localparam int WRITE_PULSE_CYC = (WRITE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_HIGH_CYC = (WRITE_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_HIGH_CYC =
		(STROBE_HIGH_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_DEPTH = 3;
	localparam int READ_LOW_CYC =
		(READ_ACCESS_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_DEPTH;

	// Longest erase times in seconds.
	localparam real CHIP_ERASE_MAX_S = 400.0;
	localparam real SECTOR_ERASE_MAX_S = 5.0;

	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	localparam int CMD_ADDR_W = 12;
	localparam int TOGGLE_STATUS_LINE = 6;

	// Command words: unlock pair, erase setup, finals, identification.
	localparam logic [11:0] UNLOCK_ADDR_1 = 12'h555;
	localparam logic [11:0] UNLOCK_ADDR_2 = 12'h2AA;
	localparam logic [7:0] UNLOCK_DATA_1 = 8'hAA;
	localparam logic [7:0] UNLOCK_DATA_2 = 8'h55;
	localparam logic [7:0] ERASE_SETUP_DATA = 8'h80;
	localparam logic [7:0] CHIP_ERASE_DATA = 8'h10;
	localparam logic [7:0] SECTOR_ERASE_DATA = 8'h30;
	localparam logic [7:0] ID_ENTRY_DATA = 8'h90;
	localparam logic [7:0] ID_EXIT_DATA = 8'hF0;
	localparam logic [2:0] ERASE_STEPS = 3'h6;
	localparam logic [2:0] ID_LONG_STEPS = 3'h3;
	localparam logic [2:0] ID_SHORT_STEPS = 3'h1;

	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_CHIP_ERASE = 3'h1,
		OP_SECTOR_ERASE = 3'h2,
		OP_ID_ENTRY = 3'h3,
		OP_ID_EXIT_LONG = 3'h4,
		OP_ID_EXIT_SHORT = 3'h5
	} op_t;

	typedef struct packed {
		op_t op;
		logic [ADDR_W-1:0] addr;
	} cmd_t;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq_out;
		logic dq_oe;
	} pins_t;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] data;
		logic last;
	} cmd_word_t;

endpackage
